// File: design/ana_ctrl_regs.sv
// Purpose: Analog regulator, test output and miscellaneous control bank
// Assumes: Avalon-MM slave on REF_CLK_IN, synchronous active-high reset
// Notes: Reset trim reaches the always-on domain through a sync handshake
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/10ps
module ana_ctrl_regs (
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    input wire logic [ana_ctrl_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic [1:0] AVS_RESPONSE_OUT,
    output logic AVS_WAITREQUEST_OUT,
    output ana_ctrl_pkg::ldo_ctrl_t RX_ADC_REG_OUT,
    output ana_ctrl_pkg::ldo_ctrl_t FRONTEND_REG_OUT,
    output ana_ctrl_pkg::ldo_ctrl_t SYNTH_VCO_REG_OUT,
    output ana_ctrl_pkg::test_out_t TEST_OUT_CTRL_OUT,
    output ana_ctrl_pkg::misc_ctrl_t MISC_CTRL_OUT,
    output logic [2:0] RESET_REF_TRIM_OUT,
    output logic HV_SYNC_BUSY_OUT
);
    import ana_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Storage and bus decode
    logic [31:0] rx_adc_r;
    logic [31:0] frontend_r;
    logic [31:0] synth_vco_r;
    logic [31:0] test_out_r;
    logic [31:0] misc_r;
    logic [2:0] trim_aon_r;
    logic [3:0] sync_cnt_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic [1:0] resp_r;
    logic [31:0] bmask;
    logic req;
    logic wr_go;
    logic hit;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            bmask[i*8 +: 8] = {8{AVS_BYTEENABLE_IN[i]}};
        end
    end

    assign req = AVS_READ_IN | AVS_WRITE_IN;
    assign wr_go = AVS_WRITE_IN & ~ack_r;
    assign AVS_WAITREQUEST_OUT = req & ~ack_r;
    assign hit = (AVS_ADDRESS_IN == RX_ADC_REG_OFS) || (AVS_ADDRESS_IN == FRONTEND_REG_OFS) ||
        (AVS_ADDRESS_IN == SYNTH_VCO_REG_OFS) || (AVS_ADDRESS_IN == TEST_OUT_OFS) ||
        (AVS_ADDRESS_IN == MISC_OFS) || (AVS_ADDRESS_IN == HV_SYNC_OFS);

    ////////////////////////////////////////////////////////////////////////////
    // One wait cycle, then acknowledge
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes, reserved bits masked
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] msk);
        merge = ((old & ~bmask) | (AVS_WRITEDATA_IN & bmask)) & msk;
    endfunction : merge

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            rx_adc_r <= LDO_RESET;
            frontend_r <= LDO_RESET;
            synth_vco_r <= LDO_RESET;
            test_out_r <= TEST_OUT_RESET;
            misc_r <= MISC_RESET;
        end else if (wr_go) begin
            unique case (AVS_ADDRESS_IN)
                RX_ADC_REG_OFS: rx_adc_r <= merge(rx_adc_r, LDO_MASK);
                FRONTEND_REG_OFS: frontend_r <= merge(frontend_r, LDO_MASK);
                SYNTH_VCO_REG_OFS: synth_vco_r <= merge(synth_vco_r, LDO_MASK);
                TEST_OUT_OFS: test_out_r <= merge(test_out_r, TEST_OUT_MASK);
                MISC_OFS: misc_r <= merge(misc_r, MISC_MASK);
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset trim high-voltage sync: written value moves after go pulse
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            sync_cnt_r <= 4'h0;
        end else if (wr_go && AVS_ADDRESS_IN == HV_SYNC_OFS && AVS_BYTEENABLE_IN[0]
                && (AVS_WRITEDATA_IN & HV_SYNC_GO) != 32'h0 && sync_cnt_r == 4'h0) begin
            sync_cnt_r <= HV_SYNC_CYCLES;
        end else if (sync_cnt_r != 4'h0) begin
            sync_cnt_r <= sync_cnt_r - 4'h1;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            trim_aon_r <= MISC_RESET[2:0];
        end else if (sync_cnt_r == 4'h1) begin
            trim_aon_r <= misc_r[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and response
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            rdata_r <= 32'h0;
            resp_r <= 2'h0;
        end else if (req & ~ack_r) begin
            resp_r <= hit ? 2'h0 : 2'h3;
            unique case (AVS_ADDRESS_IN)
                RX_ADC_REG_OFS: rdata_r <= rx_adc_r;
                FRONTEND_REG_OFS: rdata_r <= frontend_r;
                SYNTH_VCO_REG_OFS: rdata_r <= synth_vco_r;
                TEST_OUT_OFS: rdata_r <= test_out_r;
                MISC_OFS: rdata_r <= misc_r;
                HV_SYNC_OFS: rdata_r <= {28'h0, sync_cnt_r != 4'h0, trim_aon_r};
                default: rdata_r <= 32'h0;
            endcase
        end
    end

    assign AVS_READDATA_OUT = rdata_r;
    assign AVS_RESPONSE_OUT = resp_r;

    ////////////////////////////////////////////////////////////////////////////
    // Analog control outputs
    assign RX_ADC_REG_OUT = {rx_adc_r[VTRIM_HI:VTRIM_LO], rx_adc_r[REG_ON_BIT]};
    assign FRONTEND_REG_OUT = {frontend_r[VTRIM_HI:VTRIM_LO], frontend_r[REG_ON_BIT]};
    assign SYNTH_VCO_REG_OUT = {synth_vco_r[VTRIM_HI:VTRIM_LO], synth_vco_r[REG_ON_BIT]};
    // Test fields packed in register order
    assign TEST_OUT_CTRL_OUT = {test_out_r[31:22], test_out_r[16:0]};
    // Misc fields packed in register order
    assign MISC_CTRL_OUT = {misc_r[28:6], misc_r[4:3]};
    assign RESET_REF_TRIM_OUT = trim_aon_r;
    assign HV_SYNC_BUSY_OUT = sync_cnt_r != 4'h0;
endmodule : ana_ctrl_regs

// File: common/ana_ctrl_pkg.sv
// Purpose: Constants and types for the analog control register bank
// Assumes: Avalon-MM slave, 32-bit data, byte addresses
// Notes: One aligned word per register
package ana_ctrl_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] RX_ADC_REG_OFS = 8'h3c;
    localparam logic [ADDR_W-1:0] FRONTEND_REG_OFS = 8'h40;
    localparam logic [ADDR_W-1:0] SYNTH_VCO_REG_OFS = 8'h44;
    localparam logic [ADDR_W-1:0] TEST_OUT_OFS = 8'h48;
    localparam logic [ADDR_W-1:0] MISC_OFS = 8'h4c;
    localparam logic [ADDR_W-1:0] HV_SYNC_OFS = 8'h54;
    localparam logic [31:0] LDO_RESET = 32'h00000040;
    localparam logic [31:0] TEST_OUT_RESET = 32'h0f000000;
    localparam logic [31:0] MISC_RESET = 32'h00003ad3;
    localparam logic [31:0] LDO_MASK = 32'h00000079;
    localparam logic [31:0] TEST_OUT_MASK = 32'hffc1ffff;
    localparam logic [31:0] MISC_MASK = 32'h1fffffdf;
    localparam logic [31:0] HV_SYNC_GO = 32'h00000001;
    localparam int VTRIM_HI = 6;
    localparam int VTRIM_LO = 3;
    localparam int REG_ON_BIT = 0;
    localparam logic [3:0] HV_SYNC_CYCLES = 4'h4;

    typedef struct packed {
        logic [3:0] vtrim;
        logic on;
    } ldo_ctrl_t;

    typedef struct packed {
        logic [7:0] battery_load_trim;
        logic battery_const_current;
        logic battery_test_on;
        logic [1:0] test_pad_route;
        logic test_volt_out_on;
        logic test_curr_out_on;
        logic test_clk_out_on;
        logic test_flag_out_on;
        logic [3:0] test_volt_source;
        logic test_curr_source;
        logic [2:0] test_clk_source;
        logic [1:0] test_flag_source;
        logic test_volt_buffer_skip;
    } test_out_t;

    typedef struct packed {
        logic usb_pad_pullup_second;
        logic usb_pad_pullup_first;
        logic usb_pad_on;
        logic [5:0] flash_pads_pulldown;
        logic [5:0] flash_pads_pullup;
        logic [5:0] flash_pads_input_on;
        logic shifter_highpower_domain_on;
        logic shifter_alwayson_domain_on;
        logic bandgap_buffer_on;
        logic regulators_test_mode;
    } misc_ctrl_t;
endpackage : ana_ctrl_pkg

// File: tb/ana_ctrl_regs_chk.sv
// Purpose: Field and bus checks for the analog control bank
// Assumes: Full byte enables on checked writes
// Notes: Bound to the bank after the module
`timescale 1ns/10ps
module ana_ctrl_regs_chk (
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    input wire logic [ana_ctrl_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [31:0] AVS_READDATA_OUT,
    input wire logic [1:0] AVS_RESPONSE_OUT,
    input wire logic AVS_WAITREQUEST_OUT,
    input wire ana_ctrl_pkg::ldo_ctrl_t RX_ADC_REG_OUT,
    input wire ana_ctrl_pkg::ldo_ctrl_t FRONTEND_REG_OUT,
    input wire ana_ctrl_pkg::ldo_ctrl_t SYNTH_VCO_REG_OUT,
    input wire ana_ctrl_pkg::test_out_t TEST_OUT_CTRL_OUT,
    input wire ana_ctrl_pkg::misc_ctrl_t MISC_CTRL_OUT,
    input wire logic [2:0] RESET_REF_TRIM_OUT,
    input wire logic HV_SYNC_BUSY_OUT
);
    import ana_ctrl_pkg::*;
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);
    sequence s_rd(logic [7:0] ofs);
        AVS_READ_IN && AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == ofs;
    endsequence
    sequence s_wr(logic [7:0] ofs);
        AVS_WRITE_IN && AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == ofs && AVS_BYTEENABLE_IN == 4'hf;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    property p_rx; s_wr(RX_ADC_REG_OFS) |=> RX_ADC_REG_OUT ==
        {$past(AVS_WRITEDATA_IN[6:3]), $past(AVS_WRITEDATA_IN[0])}; endproperty
    property p_fe; s_wr(FRONTEND_REG_OFS) |=> FRONTEND_REG_OUT ==
        {$past(AVS_WRITEDATA_IN[6:3]), $past(AVS_WRITEDATA_IN[0])}; endproperty
    property p_vco; s_wr(SYNTH_VCO_REG_OFS) |=> SYNTH_VCO_REG_OUT ==
        {$past(AVS_WRITEDATA_IN[6:3]), $past(AVS_WRITEDATA_IN[0])}; endproperty
    property p_test; s_wr(TEST_OUT_OFS) |=> TEST_OUT_CTRL_OUT ==
        {$past(AVS_WRITEDATA_IN[31:22]), $past(AVS_WRITEDATA_IN[16:0])}; endproperty
    property p_misc; s_wr(MISC_OFS) |=> MISC_CTRL_OUT ==
        {$past(AVS_WRITEDATA_IN[28:6]), $past(AVS_WRITEDATA_IN[4:3])}; endproperty
    property p_rsvd; s_rd(RX_ADC_REG_OFS) |=> (AVS_READDATA_OUT & ~LDO_MASK) == 32'h0;
    endproperty
    property p_trim; s_wr(MISC_OFS) ##0 !HV_SYNC_BUSY_OUT |=> $stable(RESET_REF_TRIM_OUT);
    endproperty
    property p_unmap; AVS_READ_IN && AVS_WAITREQUEST_OUT && !(AVS_ADDRESS_IN inside
        {8'h3c, 8'h40, 8'h44, 8'h48, 8'h4c, 8'h54}) |=>
        AVS_RESPONSE_OUT == 2'b11 && AVS_READDATA_OUT == 32'h0; endproperty
    a_rx: assert property (p_rx) else $error("rx regulator mismatch");
    a_fe: assert property (p_fe) else $error("front-end regulator mismatch");
    a_vco: assert property (p_vco) else $error("vco regulator mismatch");
    a_test: assert property (p_test) else $error("test output mismatch");
    a_misc: assert property (p_misc) else $error("misc mismatch");
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
    a_trim: assert property (p_trim) else $error("trim changed without sync");
    a_unmap: assert property (p_unmap) else $error("unmapped read wrong");
endmodule : ana_ctrl_regs_chk
bind ana_ctrl_regs ana_ctrl_regs_chk chk (.REF_CLK_IN, .RST_IN, .AVS_ADDRESS_IN, .AVS_READ_IN,
    .AVS_WRITE_IN, .AVS_BYTEENABLE_IN, .AVS_WRITEDATA_IN, .AVS_READDATA_OUT, .AVS_RESPONSE_OUT,
    .AVS_WAITREQUEST_OUT, .RX_ADC_REG_OUT, .FRONTEND_REG_OUT, .SYNTH_VCO_REG_OUT,
    .TEST_OUT_CTRL_OUT, .MISC_CTRL_OUT, .RESET_REF_TRIM_OUT, .HV_SYNC_BUSY_OUT);

// File: tb/testbench.sv
// Purpose: Self-checking bench for the analog control bank
// Assumes: One wait cycle per access
// Notes: Row table first, then reset, decode and sync cases
`timescale 1ns/10ps
module testbench;
    import ana_ctrl_pkg::*;
    logic clk, rst, rd, wr, wreq;
    logic [7:0] adr;
    logic [31:0] wd, rdata, rdat;
    logic [1:0] resp, rsp;
    logic [2:0] trim;
    int n_errors = 0;
    int compares = 0;
    logic [7:0] ra [10] = '{8'h3c, 8'h40, 8'h44, 8'h3c, 8'h48, 8'h48, 8'h48, 8'h48, 8'h4c, 8'h4c};
    logic [31:0] rw [10] = '{32'hffffffff, 32'h41, 32'h78, 32'h1, 32'hffffffff, 32'h00c08001,
        32'h00010000, 32'h0, 32'hffffffff, 32'h0};
    logic [31:0] re [10] = '{32'h79, 32'h41, 32'h78, 32'h1, 32'hffc1ffff, 32'h00c08001,
        32'h00010000, 32'h0, 32'h1fffffdf, 32'h0};
    logic [31:0] rst_v [5] = '{LDO_RESET, LDO_RESET, LDO_RESET, TEST_OUT_RESET, MISC_RESET};
    ana_ctrl_regs uut (.REF_CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
        .AVS_WRITE_IN(wr), .AVS_BYTEENABLE_IN(4'hf), .AVS_WRITEDATA_IN(wd),
        .AVS_READDATA_OUT(rdata), .AVS_RESPONSE_OUT(resp), .AVS_WAITREQUEST_OUT(wreq),
        .RX_ADC_REG_OUT(), .FRONTEND_REG_OUT(), .SYNTH_VCO_REG_OUT(), .TEST_OUT_CTRL_OUT(),
        .MISC_CTRL_OUT(), .RESET_REF_TRIM_OUT(trim), .HV_SYNC_BUSY_OUT());
    ////////////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        rdat = rdata;
        rsp = resp;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        end_of_test;
    end
    initial begin
        rst = 1'b1; rd = 1'b0; wr = 1'b0; adr = 8'h0; wd = 32'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            bus(1'b1, ra[i], rw[i]);
            bus(1'b0, ra[i], 32'h0);
            chk(rdat, re[i]);
        end
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, 8'h3c + 8'(4 * i), 32'h0);
            chk(rdat, rst_v[i]);
        end
        chk({29'h0, trim}, 32'h3);
        bus(1'b1, 8'h50, 32'hffffffff);
        bus(1'b0, 8'h50, 32'h0);
        chk(rdat, 32'h0);
        chk({30'h0, rsp}, 32'h3);
        bus(1'b1, MISC_OFS, 32'h5);
        chk({29'h0, trim}, 32'h3);
        bus(1'b1, HV_SYNC_OFS, HV_SYNC_GO);
        repeat (4) @(posedge clk);
        chk({29'h0, trim}, 32'h5);
        end_of_test;
    end
endmodule : testbench
